// ==== dcs_pkg.sv ====
// Constants and types for the display command interpreter
package dcs_pkg;
  localparam logic [7:0] CMD_INVERT_OFF = 8'h20;
  localparam logic [7:0] CMD_INVERT_ON = 8'h21;
  localparam logic [7:0] CMD_DISPLAY_OFF = 8'h28;
  localparam logic [7:0] CMD_DISPLAY_ON = 8'h29;
  localparam logic [7:0] CMD_COLUMN_WINDOW = 8'h2A;
  localparam logic [7:0] CMD_PAGE_WINDOW = 8'h2B;
  localparam logic [7:0] CMD_MEMORY_WRITE = 8'h2C;
  localparam int ADDR_W = 9;
  localparam int PIXEL_W = 18;
  localparam logic [8:0] LIMIT_SHORT = 9'h0EF;
  localparam logic [8:0] LIMIT_LONG = 9'h1AF;
  localparam logic [8:0] WINDOW_FIRST_RESET = 9'h000;
  localparam logic [8:0] COLUMN_LAST_RESET = 9'h0EF;
  localparam logic [8:0] PAGE_LAST_RESET = 9'h13F;
  localparam logic [8:0] ADDR_ONE = 9'h001;
  // APB register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COLUMN = 8'h08;
  localparam logic [7:0] ADDR_PAGE = 8'h0C;
  localparam logic [7:0] ADDR_COUNTER = 8'h10;
  // Control register fields
  localparam int CTL_WRAP = 0;
  localparam int CTL_EXCHANGE = 1;
  localparam int CTL_COL_DIR = 2;
  localparam int CTL_PAGE_DIR = 3;
  // Status register fields
  localparam int ST_INVERT = 0;
  localparam int ST_DISPLAY = 1;
  localparam int ST_STREAM = 2;
  localparam int ST_DONE = 3;
  localparam int FIELD_HI = 16;
  typedef enum logic [1:0] {
    PARSE_IDLE = 2'b00,
    PARSE_COLUMN = 2'b01,
    PARSE_PAGE = 2'b10,
    PARSE_STREAM = 2'b11
  } parse_state_type;
endpackage : dcs_pkg

// ==== dcs_display_window_write.sv ====
// Display command decoder with window, write stream and panel gating
`timescale 1ns/10ps
module dcs_display_window_write (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_write_strobe,
  input wire logic bus_data_select,
  input wire logic [dcs_pkg::PIXEL_W-1:0] bus_data,
  input wire logic [dcs_pkg::PIXEL_W-1:0] memory_pixel,
  output logic [dcs_pkg::PIXEL_W-1:0] panel_pixel,
  output logic memory_write,
  output logic [dcs_pkg::ADDR_W-1:0] memory_column,
  output logic [dcs_pkg::ADDR_W-1:0] memory_page,
  output logic [dcs_pkg::PIXEL_W-1:0] memory_data
);
  import dcs_pkg::*;

  logic strobe_meta, strobe_sync, strobe_last;
  logic select_meta, select_sync;
  logic [PIXEL_W-1:0] data_meta, data_sync;
  logic byte_taken;
  logic is_command, is_param;
  logic [7:0] command_byte;
  parse_state_type parse_state;
  logic [1:0] param_index;
  logic [ADDR_W-1:0] hold_high, hold_first, hold_last;
  logic [ADDR_W-1:0] window_first_column, window_last_column;
  logic [ADDR_W-1:0] window_first_page, window_last_page;
  logic [ADDR_W-1:0] column_count, page_count;
  logic invert_on, display_on, window_done;
  logic write_wrap_enable, row_col_exchange, column_step_dir, page_step_dir;
  logic [ADDR_W-1:0] next_value;
  logic apb_write, apb_read;

  // Range limit for the column or page axis under the exchange bit
  function automatic logic [ADDR_W-1:0] axis_limit(input logic exchanged);
    axis_limit = exchanged ? LIMIT_LONG : LIMIT_SHORT;
  endfunction : axis_limit

  function automatic logic at_end(input logic [ADDR_W-1:0] count, input logic [ADDR_W-1:0] first,
                                  input logic [ADDR_W-1:0] last, input logic descending);
    at_end = descending ? (count == first) : (count == last);
  endfunction : at_end

  function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] count, input logic descending);
    step = descending ? count - ADDR_ONE : count + ADDR_ONE;
  endfunction : step

  // Strobe, select and data come from the pins, so all pass two flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
      strobe_last <= 1'b0;
      select_meta <= 1'b0;
      select_sync <= 1'b0;
      data_meta <= '0;
      data_sync <= '0;
    end
    else
    begin
      strobe_meta <= bus_write_strobe;
      strobe_sync <= strobe_meta;
      strobe_last <= strobe_sync;
      select_meta <= bus_data_select;
      select_sync <= select_meta;
      data_meta <= bus_data;
      data_sync <= data_meta;
    end
  end

  assign byte_taken = strobe_sync && !strobe_last;
  assign is_command = byte_taken && !select_sync;
  assign is_param = byte_taken && select_sync;
  assign command_byte = data_sync[7:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      invert_on <= 1'b0;
    else if (is_command && command_byte == CMD_INVERT_OFF)
      invert_on <= 1'b0;
    else if (is_command && command_byte == CMD_INVERT_ON)
      invert_on <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      display_on <= 1'b0;
    else if (is_command && command_byte == CMD_DISPLAY_OFF)
      display_on <= 1'b0;
    else if (is_command && command_byte == CMD_DISPLAY_ON)
      display_on <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      panel_pixel <= '0;
    else if (!display_on)
      panel_pixel <= '0;
    else
      panel_pixel <= invert_on ? ~memory_pixel : memory_pixel;
  end

  // Parameter parser; a command always restarts it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      parse_state <= PARSE_IDLE;
      param_index <= 2'd0;
    end
    else if (is_command)
    begin
      param_index <= 2'd0;
      case (command_byte)
        CMD_COLUMN_WINDOW: parse_state <= PARSE_COLUMN;
        CMD_PAGE_WINDOW: parse_state <= PARSE_PAGE;
        CMD_MEMORY_WRITE: parse_state <= PARSE_STREAM;
        default: parse_state <= PARSE_IDLE;
      endcase
    end
    else if (is_param)
    begin
      case (parse_state)
        PARSE_COLUMN, PARSE_PAGE:
        begin
          param_index <= param_index + 2'd1;
          if (param_index == 2'd3)
            parse_state <= PARSE_IDLE;
        end
        PARSE_STREAM: parse_state <= PARSE_STREAM;
        default: parse_state <= PARSE_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_high <= '0;
      hold_first <= '0;
      hold_last <= '0;
    end
    else if (is_param && (parse_state == PARSE_COLUMN || parse_state == PARSE_PAGE))
    begin
      case (param_index)
        2'd0: hold_high <= {data_sync[0], 8'h00};
        2'd1: hold_first <= {hold_high[8], data_sync[7:0]};
        2'd2: hold_high <= {data_sync[0], 8'h00};
        default: hold_last <= {hold_high[8], data_sync[7:0]};
      endcase
    end
  end

  assign next_value = {hold_high[8], data_sync[7:0]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      window_first_column <= WINDOW_FIRST_RESET;
      window_last_column <= COLUMN_LAST_RESET;
    end
    else if (is_param && parse_state == PARSE_COLUMN && param_index == 2'd3 &&
             hold_first <= axis_limit(row_col_exchange) && next_value <= axis_limit(row_col_exchange))
    begin
      window_first_column <= hold_first;
      window_last_column <= next_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      window_first_page <= WINDOW_FIRST_RESET;
      window_last_page <= PAGE_LAST_RESET;
    end
    else if (is_param && parse_state == PARSE_PAGE && param_index == 2'd3 &&
             hold_first <= axis_limit(!row_col_exchange) && next_value <= axis_limit(!row_col_exchange))
    begin
      window_first_page <= hold_first;
      window_last_page <= next_value;
    end
  end

  // Address counters for the pixel stream
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      column_count <= '0;
      page_count <= '0;
      window_done <= 1'b0;
    end
    else if (is_command && command_byte == CMD_MEMORY_WRITE)
    begin
      column_count <= column_step_dir ? window_last_column : window_first_column;
      page_count <= page_step_dir ? window_last_page : window_first_page;
      window_done <= 1'b0;
    end
    else if (is_param && parse_state == PARSE_STREAM && !window_done)
    begin
      // exchange makes page the fast axis
      if (!row_col_exchange)
      begin
        if (!at_end(column_count, window_first_column, window_last_column, column_step_dir))
          column_count <= step(column_count, column_step_dir);
        else
        begin
          column_count <= column_step_dir ? window_last_column : window_first_column;
          if (!at_end(page_count, window_first_page, window_last_page, page_step_dir))
            page_count <= step(page_count, page_step_dir);
          else
          begin
            page_count <= page_step_dir ? window_last_page : window_first_page;
            window_done <= !write_wrap_enable;
          end
        end
      end
      else
      begin
        if (!at_end(page_count, window_first_page, window_last_page, page_step_dir))
          page_count <= step(page_count, page_step_dir);
        else
        begin
          page_count <= page_step_dir ? window_last_page : window_first_page;
          if (!at_end(column_count, window_first_column, window_last_column, column_step_dir))
            column_count <= step(column_count, column_step_dir);
          else
          begin
            column_count <= column_step_dir ? window_last_column : window_first_column;
            window_done <= !write_wrap_enable;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      memory_write <= 1'b0;
      memory_column <= '0;
      memory_page <= '0;
      memory_data <= '0;
    end
    else
    begin
      memory_write <= is_param && parse_state == PARSE_STREAM && !window_done;
      memory_column <= column_count;
      memory_page <= page_count;
      memory_data <= data_sync;
    end
  end

  // APB slave, zero wait states
  assign apb_write = psel && penable && pwrite;
  assign apb_read = psel && !penable && !pwrite;

  // Address mode and wrap bits are software controlled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      write_wrap_enable <= 1'b0;
      row_col_exchange <= 1'b0;
      column_step_dir <= 1'b0;
      page_step_dir <= 1'b0;
    end
    else if (apb_write && paddr == ADDR_CONTROL)
    begin
      write_wrap_enable <= pwdata[CTL_WRAP];
      row_col_exchange <= pwdata[CTL_EXCHANGE];
      column_step_dir <= pwdata[CTL_COL_DIR];
      page_step_dir <= pwdata[CTL_PAGE_DIR];
    end
  end

  // Read data captured in setup so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      // Error flag pulses with pready only, never lingers into idle cycles
      pslverr <= psel && !penable &&
                 !(paddr == ADDR_CONTROL || paddr == ADDR_STATUS || paddr == ADDR_COLUMN ||
                   paddr == ADDR_PAGE || paddr == ADDR_COUNTER);
      if (apb_read)
      begin
        prdata <= '0;
        case (paddr)
          ADDR_CONTROL: prdata <= {28'h000_0000, page_step_dir, column_step_dir,
                                   row_col_exchange, write_wrap_enable};
          ADDR_STATUS: prdata <= {28'h000_0000, window_done, parse_state == PARSE_STREAM,
                                  display_on, invert_on};
          ADDR_COLUMN: prdata <= {7'h00, window_last_column, 7'h00, window_first_column};
          ADDR_PAGE: prdata <= {7'h00, window_last_page, 7'h00, window_first_page};
          ADDR_COUNTER: prdata <= {7'h00, page_count, 7'h00, column_count};
          default: prdata <= '0;
        endcase
      end
    end
  end
endmodule : dcs_display_window_write

// ==== dcs_host_model.sv ====
// Host processor model driving the parallel command bus
`timescale 1ns/10ps
module dcs_host_model (
  input wire logic pclk,
  output logic bus_write_strobe,
  output logic bus_data_select,
  output logic [dcs_pkg::PIXEL_W-1:0] bus_data
);
  import dcs_pkg::*;
  initial
  begin
    bus_write_strobe = 1'b0;
    bus_data_select = 1'b1;
    bus_data = 18'h0_0000;
  end
  task automatic send(input logic dc, input logic [PIXEL_W-1:0] value);
    @(posedge pclk);
    bus_data_select <= dc;
    bus_data <= value;
    repeat (4) @(posedge pclk);
    bus_write_strobe <= 1'b1;
    repeat (4) @(posedge pclk);
    bus_write_strobe <= 1'b0;
    repeat (2) @(posedge pclk);
    // Released lines must not keep the last word
    bus_data <= ~value;
  endtask : send
endmodule : dcs_host_model

// ==== dcs_checker_props.sv ====
// Port-level assertions for the display command interpreter
`timescale 1ns/10ps
module dcs_checker_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_write_strobe,
  input wire logic bus_data_select,
  input wire logic [dcs_pkg::PIXEL_W-1:0] bus_data,
  input wire logic [dcs_pkg::PIXEL_W-1:0] memory_pixel,
  input wire logic [dcs_pkg::PIXEL_W-1:0] panel_pixel,
  input wire logic memory_write,
  input wire logic [dcs_pkg::ADDR_W-1:0] memory_column,
  input wire logic [dcs_pkg::ADDR_W-1:0] memory_page,
  input wire logic [dcs_pkg::PIXEL_W-1:0] memory_data
);
  import dcs_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel && !penable |=> pready)
    else $error("access phase without pready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_refused_read: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0000_0000))
    else $error("bad refused transfer");
  a_panel_source: assert property (panel_pixel != '0 |->
    panel_pixel == $past(memory_pixel) || panel_pixel == ~$past(memory_pixel))
    else $error("panel pixel not from memory");
  a_write_cause: assert property (memory_write |-> $past(bus_data_select, 2) && $past(bus_write_strobe, 2))
    else $error("store without parameter strobe");
  a_write_data: assert property (memory_write |-> memory_data == $past(bus_data, 2))
    else $error("stored data differs");
  a_addr_limit: assert property (memory_write |-> memory_column <= LIMIT_LONG && memory_page <= LIMIT_LONG)
    else $error("store outside frame");
  a_cmd_stops: assert property ($rose(bus_write_strobe) && !bus_data_select |=> !memory_write [*6])
    else $error("store after command");
  c_store: cover property (memory_write);
  c_refused: cover property (pslverr);
  c_inverted: cover property (panel_pixel != '0 && panel_pixel == ~$past(memory_pixel));
endmodule : dcs_checker_props
bind dcs_display_window_write dcs_checker_props chk (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .bus_write_strobe, .bus_data_select, .bus_data, .memory_pixel, .panel_pixel,
  .memory_write, .memory_column, .memory_page, .memory_data);

// ==== tb_top.sv ====
// Self-checking bench for the display command interpreter
`timescale 1ns/10ps
module tb_top;
  import dcs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, bus_write_strobe, bus_data_select, memory_write;
  logic [PIXEL_W-1:0] memory_pixel = 18'h2_5A3C;
  logic [PIXEL_W-1:0] bus_data, panel_pixel, memory_data;
  logic [ADDR_W-1:0] memory_column, memory_page;
  logic [35:0] seen[$];
  int num_errors = 0;
  int samples_checked = 0;
  always #25 pclk = ~pclk;
  dcs_display_window_write uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bus_write_strobe, .bus_data_select, .bus_data, .memory_pixel, .panel_pixel,
    .memory_write, .memory_column, .memory_page, .memory_data);
  dcs_host_model host (.pclk, .bus_write_strobe, .bus_data_select, .bus_data);
  always @(posedge pclk)
    if (memory_write === 1'b1)
      seen.push_back({memory_column, memory_page, memory_data});
  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Bit 32 of v is the expected pslverr
  task automatic reg_io(input logic wr, input logic [7:0] addr, input logic [32:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= v[31:0];
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      num_errors++;
      give_verdict();
    end
    check(36'({pslverr, wr ? v[31:0] : prdata}), 36'(v));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : reg_io
  task automatic cmd(input logic [7:0] code);
    host.send(1'b0, {10'h3FF, code});
  endtask : cmd
  task automatic win(input logic [7:0] code, input logic [8:0] first, input logic [8:0] last);
    cmd(code);
    host.send(1'b1, {17'h0_0000, first[8]});
    host.send(1'b1, {10'h000, first[7:0]});
    host.send(1'b1, {17'h0_0000, last[8]});
    host.send(1'b1, {10'h000, last[7:0]});
  endtask : win
  // Pixels into the 5..6 by 110h..111h window, judged against the store log
  task automatic burst(input int n, input logic [3:0] mode, input logic stop);
    logic [35:0] want[$];
    logic [17:0] pix;
    int j;
    reg_io(1'b1, ADDR_CONTROL, {29'h0, mode});
    seen.delete();
    cmd(CMD_MEMORY_WRITE);
    for (int i = 0; i < n; i++)
    begin
      pix = 18'h3_0100 + 18'(i);
      j = i % 4;
      host.send(1'b1, pix);
      if (mode[0] || i < 4)
        want.push_back(mode[1] ? {9'h006 - 9'(j / 2), 9'h111 - 9'(j % 2), pix}
          : {9'h005 + 9'(j % 2), 9'h110 + 9'(j / 2), pix});
    end
    if (stop)
    begin
      cmd(CMD_INVERT_OFF);
      host.send(1'b1, 18'h1_2345);
    end
    check(36'(seen.size()), 36'(want.size()));
    foreach (want[i])
      check(seen.size() > i ? seen[i] : 36'h0_0000_0000, want[i]);
    reg_io(1'b0, ADDR_STATUS, {29'h0, n > 4 && !mode[0], !stop, 2'b10});
  endtask : burst
  task automatic t_reset_regs();
    reg_io(1'b0, ADDR_STATUS, 33'h0_0000_0000);
    reg_io(1'b0, ADDR_COLUMN, 33'h0_00EF_0000);
    reg_io(1'b0, ADDR_PAGE, 33'h0_013F_0000);
    reg_io(1'b1, 8'h14, 33'h1_0000_0000);
    reg_io(1'b0, 8'h14, 33'h1_0000_0000);
  endtask : t_reset_regs
  task automatic t_modes();
    logic [7:0] codes[8] = '{CMD_DISPLAY_ON, CMD_INVERT_ON, CMD_INVERT_ON, CMD_INVERT_OFF, CMD_INVERT_OFF,
      CMD_DISPLAY_OFF, CMD_DISPLAY_OFF, CMD_DISPLAY_ON};
    logic [1:0] mode[8] = '{2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h0, 2'h0, 2'h2};
    foreach (codes[i])
    begin
      cmd(codes[i]);
      check(36'(panel_pixel), 36'(mode[i][1] ? memory_pixel ^ {18{mode[i][0]}} : 18'h0_0000));
      reg_io(1'b0, ADDR_STATUS, {31'h0, mode[i]});
    end
  endtask : t_modes
  task automatic t_windows();
    win(CMD_COLUMN_WINDOW, 9'h005, 9'h006);
    win(CMD_PAGE_WINDOW, 9'h110, 9'h111);
    win(CMD_COLUMN_WINDOW, 9'h000, 9'h0F0);
    win(CMD_PAGE_WINDOW, 9'h000, 9'h1B0);
    reg_io(1'b0, ADDR_COLUMN, 33'h0_0006_0005);
    reg_io(1'b0, ADDR_PAGE, 33'h0_0111_0110);
  endtask : t_windows
  task automatic t_stream();
    burst(5, 4'h0, 1'b0);
    burst(9, 4'h1, 1'b0);
    burst(6, 4'hF, 1'b0);
    burst(2, 4'h0, 1'b1);
  endtask : t_stream
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_regs();
    t_modes();
    t_windows();
    t_stream();
    give_verdict();
  end
endmodule : tb_top
